// file: hdl/ampseq_pkg.sv
package ampseq_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CLK_MHZ          = 250;
	localparam int unsigned SD_MIN_US        = 1000;
	localparam int unsigned T_START_US       = 18000;
	localparam int unsigned T_TIMEOUT_US     = 25000;
	localparam int unsigned T_OFF_US         = 1000;
	localparam int unsigned SD_MIN_CYC       = SD_MIN_US * CLK_MHZ;
	localparam int unsigned T_START_CYC      = T_START_US * CLK_MHZ;
	localparam int unsigned T_TIMEOUT_CYC    = T_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned T_OFF_CYC        = T_OFF_US * CLK_MHZ;
	localparam int unsigned RATE_HI_KHZ      = 192;
	localparam int unsigned RATE_LO_KHZ      = 76;
	localparam int unsigned RATE_HI_DIV      = (CLK_MHZ * 1000) / RATE_HI_KHZ;
	localparam int unsigned RATE_LO_DIV      = (CLK_MHZ * 1000) / RATE_LO_KHZ;

	// ==========================================================
	// Modes and states
	// ==========================================================
	typedef enum logic [1:0] {
		MODE_STANDARD     = 2'h0,
		MODE_REDUCED_STD  = 2'h1,
		MODE_HYBRID       = 2'h2,
		MODE_REDUCED_HYB  = 2'h3
	} ampseq_mode_e;

	typedef enum logic [2:0] {
		ST_OFF      = 3'h0,
		ST_START    = 3'h1,
		ST_ZC_WAIT  = 3'h2,
		ST_ACTIVE   = 3'h3,
		ST_PWR_DOWN = 3'h4
	} ampseq_state_e;

endpackage : ampseq_pkg

// file: hdl/ampseq_sd_filter.sv
`timescale 1ns/1ps
// ==========================================================
// Shutdown pin synchroniser and low-width filter
// ==========================================================
module ampseq_sd_filter #(
	parameter int unsigned MIN_CYC = ampseq_pkg::SD_MIN_CYC
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Pin
	input  wire logic shutdown_n_pin,
	// Filtered level
	output logic      run_r
);
	localparam int W = $clog2(MIN_CYC + 1);

	logic         sync1_r;
	logic         sync2_r;
	logic [W-1:0] low_cnt_r;
	logic [W-1:0] low_cnt_nxt;
	logic         low_done;

	// A low must persist for the whole minimum width before the device honours it.
	assign low_done    = (low_cnt_r == W'(MIN_CYC - 1));
	assign low_cnt_nxt = sync2_r ? '0 : (low_done ? low_cnt_r : low_cnt_r + W'(1));

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync1_r   <= 1'b0;
			sync2_r   <= 1'b0;
			low_cnt_r <= '0;
			run_r     <= 1'b0;
		end else begin
			sync1_r   <= shutdown_n_pin;
			sync2_r   <= sync1_r;
			low_cnt_r <= low_cnt_nxt;
			if (sync2_r)
				run_r <= 1'b1;
			else if (low_done)
				run_r <= 1'b0;
		end
	end

	a_short_low_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
		run_r && !sync2_r && !low_done |=> run_r)
		else $error("Short shutdown pulse dropped the run level.");

endmodule : ampseq_sd_filter

// file: hdl/ampseq_rate_gen.sv
`timescale 1ns/1ps
// ==========================================================
// Switching rate enable generator
// ==========================================================
module ampseq_rate_gen #(
	parameter int unsigned HI_DIV = ampseq_pkg::RATE_HI_DIV,
	parameter int unsigned LO_DIV = ampseq_pkg::RATE_LO_DIV
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Control
	input  wire logic run,
	input  wire logic slow,
	// Enable pulse
	output logic      tick_r
);
	localparam int W = $clog2(LO_DIV + 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] limit;
	logic         wrap;

	assign limit = slow ? W'(LO_DIV - 1) : W'(HI_DIV - 1);
	assign wrap  = (cnt_r >= limit);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= (!run || wrap) ? '0 : cnt_r + W'(1);
			tick_r <= run && wrap;
		end
	end

endmodule : ampseq_rate_gen

// file: hdl/ampseq_top.sv
`timescale 1ns/1ps
// ==========================================================
// Amplifier shutdown and mode sequencer
// ==========================================================
module ampseq_top #(
	parameter int unsigned START_CYC   = ampseq_pkg::T_START_CYC,
	parameter int unsigned TIMEOUT_CYC = ampseq_pkg::T_TIMEOUT_CYC,
	parameter int unsigned OFF_CYC     = ampseq_pkg::T_OFF_CYC,
	parameter int unsigned SD_MIN      = ampseq_pkg::SD_MIN_CYC,
	parameter int unsigned HI_DIV      = ampseq_pkg::RATE_HI_DIV,
	parameter int unsigned LO_DIV      = ampseq_pkg::RATE_LO_DIV
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Host pins and straps
	input  wire logic        shutdown_n_pin,
	input  wire logic        mode_strap,
	input  wire logic        rail_filter_strap,
	// Analog status
	input  wire logic        supply_ok,
	input  wire logic        zero_cross,
	input  wire logic        low_amplitude,
	input  wire logic        transient_high,
	// Output stage control
	output logic             out_hiz_r,
	output logic             switch_en_r,
	output logic             switch_tick_r,
	output logic             slow_rate_r,
	output logic             rail_low_r,
	output logic             low_power_r,
	output logic             ready_r,
	output logic       [1:0] mode_r
);
	localparam int W = $clog2(TIMEOUT_CYC + START_CYC + 1);

	ampseq_pkg::ampseq_state_e st_r;
	ampseq_pkg::ampseq_state_e st_nxt;
	ampseq_pkg::ampseq_mode_e  mode_nxt;

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         run;
	logic         tick;
	logic         start_done;
	logic         zc_timeout;
	logic         off_done;
	logic         hybrid;
	logic         slow_nxt;
	logic         rail_low_nxt;
	logic         active_nxt;
	logic         strap_m_r;
	logic         strap_m_nxt;
	logic         strap_rf_r;
	logic         strap_rf_nxt;

	// ==========================================================
	// Submodules
	// ==========================================================
	ampseq_sd_filter #(
		.MIN_CYC        (SD_MIN)
	) u_filt (
		.clk_sys        (clk_sys),
		.rstn           (rstn),
		.shutdown_n_pin (shutdown_n_pin),
		.run_r          (run)
	);

	ampseq_rate_gen #(
		.HI_DIV  (HI_DIV),
		.LO_DIV  (LO_DIV)
	) u_rate (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.run     (active_nxt),
		.slow    (slow_nxt),
		.tick_r  (tick)
	);

	// ==========================================================
	// Mode decode
	// ==========================================================
	// Strap high means tied to the supply; a low rail-filter strap means a capacitor is fitted.
	function automatic ampseq_pkg::ampseq_mode_e decode_mode(input logic m, input logic rf, input logic ok);
		ampseq_pkg::ampseq_mode_e r;
		r = ampseq_pkg::MODE_STANDARD;
		if (rf || !ok)
			r = m ? ampseq_pkg::MODE_STANDARD : ampseq_pkg::MODE_REDUCED_STD;
		else
			r = m ? ampseq_pkg::MODE_HYBRID : ampseq_pkg::MODE_REDUCED_HYB;
		if (!ok)
			r = ampseq_pkg::MODE_STANDARD;
		return r;
	endfunction : decode_mode

	// The straps are latched only during start-up; a strap moved later waits for the next start-up.
	assign strap_m_nxt  = (st_r == ampseq_pkg::ST_START) ? mode_strap : strap_m_r;
	assign strap_rf_nxt = (st_r == ampseq_pkg::ST_START) ? rail_filter_strap : strap_rf_r;

	// The supply limit is watched continuously, so a sagging battery leaves hybrid at once.
	// The latched straps outlive the dip, so the chosen mode returns when the battery recovers.
	assign mode_nxt = decode_mode(strap_m_nxt, strap_rf_nxt, supply_ok);

	assign hybrid = (mode_nxt == ampseq_pkg::MODE_HYBRID) || (mode_nxt == ampseq_pkg::MODE_REDUCED_HYB);

	assign slow_nxt = (mode_nxt == ampseq_pkg::MODE_REDUCED_STD)
		|| ((mode_nxt == ampseq_pkg::MODE_REDUCED_HYB) && transient_high);

	assign rail_low_nxt = active_nxt && hybrid && low_amplitude;

	// ==========================================================
	// Sequencer
	// ==========================================================
	assign start_done = (cnt_r == W'(START_CYC - 1));
	assign zc_timeout = (cnt_r == W'(START_CYC + TIMEOUT_CYC - 1));
	assign off_done   = (cnt_r == W'(OFF_CYC - 1));

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r + W'(1);
		case (st_r)
			ampseq_pkg::ST_OFF: begin
				cnt_nxt = '0;
				if (run)
					st_nxt = ampseq_pkg::ST_START;
			end
			ampseq_pkg::ST_START: begin
				if (!run) begin
					st_nxt  = ampseq_pkg::ST_PWR_DOWN;
					cnt_nxt = '0;
				end else if (start_done)
					st_nxt = ampseq_pkg::ST_ZC_WAIT;
			end
			ampseq_pkg::ST_ZC_WAIT: begin
				if (!run) begin
					st_nxt  = ampseq_pkg::ST_PWR_DOWN;
					cnt_nxt = '0;
				end else if (zero_cross || zc_timeout)
					st_nxt = ampseq_pkg::ST_ACTIVE;
			end
			ampseq_pkg::ST_ACTIVE: begin
				cnt_nxt = '0;
				if (!run)
					st_nxt = ampseq_pkg::ST_PWR_DOWN;
			end
			ampseq_pkg::ST_PWR_DOWN: begin
				if (off_done) begin
					st_nxt  = ampseq_pkg::ST_OFF;
					cnt_nxt = '0;
				end
			end
			default: begin
				st_nxt  = ampseq_pkg::ST_OFF;
				cnt_nxt = '0;
			end
		endcase
	end

	assign active_nxt = (st_nxt == ampseq_pkg::ST_ACTIVE);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_r       <= ampseq_pkg::ST_OFF;
			cnt_r      <= '0;
			strap_m_r  <= 1'b1;
			strap_rf_r <= 1'b1;
		end else begin
			st_r       <= st_nxt;
			cnt_r      <= cnt_nxt;
			strap_m_r  <= strap_m_nxt;
			strap_rf_r <= strap_rf_nxt;
		end
	end

	// ==========================================================
	// Registered outputs
	// ==========================================================
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			out_hiz_r     <= 1'b1;
			switch_en_r   <= 1'b0;
			switch_tick_r <= 1'b0;
			slow_rate_r   <= 1'b0;
			rail_low_r    <= 1'b0;
			low_power_r   <= 1'b1;
			ready_r       <= 1'b0;
			mode_r        <= ampseq_pkg::MODE_STANDARD;
		end else begin
			out_hiz_r     <= !active_nxt;
			switch_en_r   <= active_nxt;
			switch_tick_r <= tick;
			slow_rate_r   <= active_nxt && slow_nxt;
			rail_low_r    <= rail_low_nxt;
			low_power_r   <= (st_nxt == ampseq_pkg::ST_OFF);
			ready_r       <= (st_nxt == ampseq_pkg::ST_ZC_WAIT) || active_nxt;
			mode_r        <= mode_nxt;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	sequence s_released;
		st_r == ampseq_pkg::ST_OFF ##1 st_r == ampseq_pkg::ST_START;
	endsequence

	sequence s_start_done;
		(st_r == ampseq_pkg::ST_START) && start_done && run;
	endsequence

	a_start_no_early: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_released |-> !switch_en_r [*8])
		else $error("Outputs enabled before start-up ended.");

	a_zc_bounded: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_ZC_WAIT) && zc_timeout && run |=> st_r == ampseq_pkg::ST_ACTIVE)
		else $error("Zero-crossing wait overran its timeout.");

	a_total_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_ZC_WAIT) |-> cnt_r < W'(START_CYC + TIMEOUT_CYC))
		else $error("Power-up delay exceeded start plus timeout.");

	a_zc_enables: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_ZC_WAIT) && zero_cross && run |=> switch_en_r && !out_hiz_r)
		else $error("Zero-crossing did not enable outputs.");

	a_off_bounded: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_PWR_DOWN) |-> cnt_r < W'(OFF_CYC))
		else $error("Power-down exceeded its interval.");

	a_hiz_when_down: assert property (@(posedge clk_sys) disable iff (!rstn)
		!run |=> out_hiz_r && !switch_en_r)
		else $error("Outputs driven while shut down.");

	a_low_supply_std: assert property (@(posedge clk_sys) disable iff (!rstn)
		!supply_ok |=> mode_r == ampseq_pkg::MODE_STANDARD && !rail_low_r)
		else $error("Hybrid mode kept under low supply.");

	a_mode_held: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_ACTIVE) && supply_ok && $stable(supply_ok) |=> $stable(mode_r))
		else $error("Mode changed while active.");

	a_std_rate_fast: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mode_r == ampseq_pkg::MODE_STANDARD || mode_r == ampseq_pkg::MODE_HYBRID) |-> !slow_rate_r)
		else $error("Slow rate outside reduced modes.");

	a_rail_low_hybrid: assert property (@(posedge clk_sys) disable iff (!rstn)
		rail_low_r |-> mode_r[1])
		else $error("Regulator rail used outside hybrid modes.");

	a_ready_on_time: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_start_done |=> ready_r && st_r == ampseq_pkg::ST_ZC_WAIT)
		else $error("Start-up end did not reach the crossing wait.");

	a_start_length: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_START) |-> cnt_r < W'(START_CYC))
		else $error("Start-up interval overran.");

	a_off_reached: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_PWR_DOWN) && off_done |=> low_power_r && st_r == ampseq_pkg::ST_OFF)
		else $error("Power-down did not end in the low-power state.");

	a_mode_decode: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_START) && supply_ok |=> mode_r == {~$past(rail_filter_strap), ~$past(mode_strap)})
		else $error("Strap decode gave the wrong mode.");

	a_reduced_std_slow: assert property (@(posedge clk_sys) disable iff (!rstn)
		switch_en_r && mode_r == ampseq_pkg::MODE_REDUCED_STD |-> slow_rate_r)
		else $error("Reduced standard mode not at the slow rate.");

	a_reduced_hyb_rate: assert property (@(posedge clk_sys) disable iff (!rstn)
		switch_en_r && mode_r == ampseq_pkg::MODE_REDUCED_HYB |-> slow_rate_r == $past(transient_high))
		else $error("Reduced hybrid rate did not follow transients.");

	a_rail_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
		switch_en_r && mode_r[1] |-> rail_low_r == $past(low_amplitude))
		else $error("Hybrid rail did not follow the amplitude.");

	a_tick_when_on: assert property (@(posedge clk_sys) disable iff (!rstn)
		switch_tick_r |-> $past(switch_en_r))
		else $error("Switching tick while outputs disabled.");

	a_zc_hold_off: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st_r == ampseq_pkg::ST_ZC_WAIT) && !zero_cross && !zc_timeout |=> !switch_en_r)
		else $error("Outputs enabled without a zero-crossing.");

	a_low_power_hiz: assert property (@(posedge clk_sys) disable iff (!rstn)
		low_power_r |-> out_hiz_r && !switch_en_r)
		else $error("Outputs driven in the low-power state.");

endmodule : ampseq_top

// file: sim/ampseq_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host controller driving the shutdown pin and straps
// ==========================================================
module ampseq_host_model #(
	parameter int unsigned SD_MIN = 5
) (
	// Clock
	input  wire logic clk_sys,
	// Pins
	output logic      shutdown_n_pin,
	output logic      mode_strap,
	output logic      rail_filter_strap
);
	int low_cyc;

	initial begin
		shutdown_n_pin = 1'b0;
		mode_strap = 1'b1;
		rail_filter_strap = 1'b1;
	end

	always @(posedge clk_sys) begin
		low_cyc <= shutdown_n_pin ? 0 : low_cyc + 1;
	end

	task automatic set_pins(input logic sd, input logic m, input logic rf);
		@(posedge clk_sys);
		#1;
		shutdown_n_pin = sd;
		mode_strap = m;
		rail_filter_strap = rf;
	endtask : set_pins

	task automatic drop_pin();
		set_pins(1'b0, mode_strap, rail_filter_strap);
	endtask : drop_pin

	// Straps move only while the pin is low, and the pin never rises early.
	task automatic release_pin(input logic m, input logic rf);
		set_pins(1'b0, m, rf);
		while (low_cyc < SD_MIN) @(posedge clk_sys);
		set_pins(1'b1, m, rf);
	endtask : release_pin

	// A too-short low pulse is sent only when a test asks for one.
	task automatic glitch(input int cyc);
		drop_pin();
		repeat (cyc) @(posedge clk_sys);
		#1;
		shutdown_n_pin = 1'b1;
	endtask : glitch
endmodule : ampseq_host_model

// file: sim/ampseq_top_tb.sv
`timescale 1ns/1ps
module ampseq_top_tb;
	localparam int unsigned START = 20;
	localparam int unsigned TOUT  = 30;
	localparam int unsigned OFF   = 10;
	localparam int unsigned SDMIN = 5;
	localparam int unsigned HDIV  = 4;
	localparam int unsigned LDIV  = 10;

	logic       clk_sys;
	logic       rstn;
	logic       supply_ok;
	logic       zero_cross;
	logic       low_amplitude;
	logic       transient_high;
	logic       shutdown_n_pin;
	logic       mode_strap;
	logic       rail_filter_strap;
	logic       out_hiz_r;
	logic       switch_en_r;
	logic       switch_tick_r;
	logic       slow_rate_r;
	logic       rail_low_r;
	logic       low_power_r;
	logic       ready_r;
	logic [1:0] mode_r;
	int         fails;
	int         checks_done;

	ampseq_host_model #(.SD_MIN(SDMIN)) i_host (.clk_sys(clk_sys), .shutdown_n_pin(shutdown_n_pin),
		.mode_strap(mode_strap), .rail_filter_strap(rail_filter_strap));

	ampseq_top #(.START_CYC(START), .TIMEOUT_CYC(TOUT), .OFF_CYC(OFF), .SD_MIN(SDMIN), .HI_DIV(HDIV),
		.LO_DIV(LDIV)) i_ampseq_top (.clk_sys(clk_sys), .rstn(rstn), .shutdown_n_pin(shutdown_n_pin),
		.mode_strap(mode_strap), .rail_filter_strap(rail_filter_strap), .supply_ok(supply_ok),
		.zero_cross(zero_cross), .low_amplitude(low_amplitude), .transient_high(transient_high),
		.out_hiz_r(out_hiz_r), .switch_en_r(switch_en_r), .switch_tick_r(switch_tick_r),
		.slow_rate_r(slow_rate_r), .rail_low_r(rail_low_r), .low_power_r(low_power_r),
		.ready_r(ready_r), .mode_r(mode_r));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	function automatic logic sig(input int s);
		case (s)
			0: return ready_r;
			1: return switch_en_r;
			2: return low_power_r;
			3: return switch_tick_r;
			default: return out_hiz_r;
		endcase
	endfunction : sig

	task automatic test_done();
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic err(input string m);
		fails++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask : err

	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) err(m);
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic wait_sig(input int s, input logic v, input int max, output int n);
		n = 0;
		while (sig(s) !== v && n < max) begin
			step(1);
			n++;
		end
		if (sig(s) !== v) begin
			err("wait timed out");
			test_done();
		end
	endtask : wait_sig

	task automatic power_up(input logic m, input logic rf, input logic use_zc);
		int n;
		int t;
		i_host.release_pin(m, rf);
		wait_sig(0, 1'b1, START + 8, n);
		chk(n >= START && switch_en_r === 1'b0, "ready too early");
		t = n;
		if (use_zc) begin
			step(5);
			chk(switch_en_r === 1'b0 && out_hiz_r === 1'b1, "enabled without crossing");
			zero_cross = 1'b1;
			step(1);
			zero_cross = 1'b0;
			wait_sig(1, 1'b1, 4, n);
		end else begin
			wait_sig(1, 1'b1, TOUT + 8, n);
			chk(t + n >= START + TOUT && t + n <= START + TOUT + 8, "timeout length");
		end
		chk(out_hiz_r === 1'b0 && low_power_r === 1'b0, "outputs not active");
	endtask : power_up

	// Measures the spacing of two ticks after the rate has settled.
	task automatic period(input int div);
		int n;
		wait_sig(3, 1'b1, LDIV + 4, n);
		step(1);
		wait_sig(3, 1'b1, LDIV + 4, n);
		chk(n + 1 == div, "switching period");
	endtask : period

	task automatic power_down();
		int n;
		int t;
		i_host.drop_pin();
		wait_sig(4, 1'b1, SDMIN + 6, n);
		chk(n >= SDMIN, "shutdown taken before filter width");
		t = n;
		wait_sig(2, 1'b1, OFF + 6, n);
		chk(n + t >= SDMIN + OFF && switch_en_r === 1'b0 && out_hiz_r === 1'b1, "power-down");
	endtask : power_down

	task automatic t_modes();
		logic       m;
		logic       rf;
		logic [1:0] exp;
		for (int i = 0; i < 4; i++) begin
			m = i[0];
			rf = i[1];
			exp = {~rf, ~m};
			power_up(m, rf, i != 0);
			chk(mode_r === exp && slow_rate_r === (exp == 2'h1), "mode decode");
			period(exp == 2'h1 ? LDIV : HDIV);
			transient_high = 1'b1;
			low_amplitude = 1'b1;
			step(3);
			chk(slow_rate_r === exp[0] && rail_low_r === exp[1], "rate or rail");
			period(exp[0] ? LDIV : HDIV);
			transient_high = 1'b0;
			low_amplitude = 1'b0;
			step(3);
			chk(rail_low_r === 1'b0 && slow_rate_r === (exp == 2'h1), "full amplitude");
			i_host.set_pins(1'b1, ~m, ~rf);
			step(3);
			chk(mode_r === exp, "mode changed while active");
			power_down();
		end
	endtask : t_modes

	task automatic t_supply();
		supply_ok = 1'b0;
		low_amplitude = 1'b1;
		power_up(1'b1, 1'b0, 1'b1);
		step(3);
		chk(mode_r === 2'h0 && rail_low_r === 1'b0, "hybrid on low supply");
		supply_ok = 1'b1;
		step(3);
		chk(mode_r === 2'h2 && rail_low_r === 1'b1, "hybrid after supply recovers");
		low_amplitude = 1'b0;
		power_down();
	endtask : t_supply

	task automatic t_short();
		power_up(1'b1, 1'b1, 1'b1);
		i_host.glitch(SDMIN - 2);
		step(SDMIN + 6);
		chk(switch_en_r === 1'b1 && out_hiz_r === 1'b0, "short pulse taken");
		power_down();
	endtask : t_short

	initial begin
		rstn = 1'b0;
		supply_ok = 1'b1;
		zero_cross = 1'b0;
		low_amplitude = 1'b0;
		transient_high = 1'b0;
		fails = 0;
		checks_done = 0;
		step(3);
		chk(out_hiz_r === 1'b1 && low_power_r === 1'b1 && switch_en_r === 1'b0 && mode_r === 2'h0,
			"reset values");
		rstn = 1'b1;
		step(2);
		t_modes();
		t_supply();
		t_short();
		test_done();
	end
endmodule : ampseq_top_tb
